/* File: rtl/cmi_pkg.sv */
// constants for the clock monitor interrupt aggregator
//
// What this block does
// RL1: interrupt out when overall enable and status
// RL2: five per-source enables gate their status bits
// RL3: overall status ORs enabled source status bits
// RL4: gated interrupt drives status pin when selected
// RL5: each status bit mirrors its monitor event
// RL6: enables and status bits reset to zero
// RL7: loss flag set on reset, sticky, W1C
// RL8: status writes ignored, reserved bits behave
package cmi_pkg;

  // ------------------------------------------------------------
  // register indices on the serial-port register path
  // ------------------------------------------------------------
  localparam logic [1:0] IDX_IRQ_ENABLE  = 2'h0;
  localparam logic [1:0] IDX_IRQ_STATUS  = 2'h1;
  localparam logic [1:0] IDX_EVENT_CLEAR = 2'h2;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int OVERALL_BIT = 15;
  localparam int SRC_LSB     = 4;
  localparam int NUM_SRC     = 5;

  // ------------------------------------------------------------
  // masks and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] EN_RW_MASK  = 16'h8FF0;
  localparam logic [15:0] EN_RESET    = 16'h0000;
  localparam logic [15:0] STS_RESET   = 16'h0000;
  // source order: los_pos, los_neg, los_xtal, act_pos, act_neg
  localparam logic [4:0]  FLAG_RESET  = 5'h07;
  localparam int          SYNC_STAGES = 2;

endpackage : cmi_pkg

/* File: rtl/cmi_event_flag.sv */
// one sticky monitor event flag with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module cmi_event_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic cond,
  input  wire logic clr,
  output var  logic flag
);

  // ------------------------------------------------------------
  // flag storage
  // ------------------------------------------------------------
  // set wins over clear, so a persisting condition blocks the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag <= RESET_VAL;                                 // [RL7]
    end else begin
      flag <= cond | (flag & ~clr);                      // [RL7]
    end
  end

endmodule : cmi_event_flag
`default_nettype wire

/* File: rtl/cmi_irq_aggregator.sv */
// clock monitor interrupt aggregator top
`timescale 1ns/1ps
`default_nettype none
module cmi_irq_aggregator #(
  parameter int NUM_SRC = cmi_pkg::NUM_SRC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // monitor conditions, asynchronous levels
  input  wire logic        los_pos_cond,
  input  wire logic        los_neg_cond,
  input  wire logic        los_xtal_cond,
  input  wire logic        act_pos_cond,
  input  wire logic        act_neg_cond,
  // register path from the serial port
  input  wire logic [1:0]  reg_index,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // status pin source selection
  input  wire logic        status_output_select,
  input  wire logic        alt_pin_status,
  output logic             device_irq,
  output logic             status_output_pin
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (NUM_SRC != 5) begin : g_bad_num
    $error("cmi_irq_aggregator serves exactly five sources");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [4:0] cond_raw;
  logic [4:0] cond_meta;
  logic [4:0] cond_sync;

  assign cond_raw = {act_neg_cond, act_pos_cond, los_xtal_cond,
                     los_neg_cond, los_pos_cond};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cond_meta <= 5'h00;
      cond_sync <= 5'h00;
    end else begin
      cond_meta <= cond_raw;
      cond_sync <= cond_meta;
    end
  end

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire        wr_enable = reg_wr && (reg_index == cmi_pkg::IDX_IRQ_ENABLE);
  wire        wr_clear  = reg_wr && (reg_index == cmi_pkg::IDX_EVENT_CLEAR);
  wire [4:0]  clr_bits  = wr_clear ? reg_wdata[8:4] : 5'h00;

  // ------------------------------------------------------------
  // event flags
  // ------------------------------------------------------------
  logic [4:0] evt_flag;

  for (genvar i = 0; i < 5; i++) begin : g_flag
    cmi_event_flag #(
      .RESET_VAL (cmi_pkg::FLAG_RESET[i])
    ) u_flag (
      .clk     (clk),
      .sys_rst (sys_rst),
      .cond    (cond_sync[i]),
      .clr     (clr_bits[i]),
      .flag    (evt_flag[i])
    );
  end

  // ------------------------------------------------------------
  // enable and status registers
  // ------------------------------------------------------------
  logic [15:0] irq_enable_control;
  logic [4:0]  src_status;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_enable_control <= cmi_pkg::EN_RESET;           // [RL6]
    end else if (wr_enable) begin
      irq_enable_control <= reg_wdata & cmi_pkg::EN_RW_MASK; // [RL8]
    end
  end

  // status bits are registered copies so their reset value is zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_status <= cmi_pkg::STS_RESET[8:4];             // [RL6]
    end else begin
      src_status <= evt_flag;                            // [RL5]
    end
  end

  wire [4:0] src_enable  = irq_enable_control[8:4];
  wire       overall_en  = irq_enable_control[cmi_pkg::OVERALL_BIT];
  wire       overall_sts = |(src_status & src_enable);   // [RL2] [RL3]
  wire       irq_gated   = overall_en & overall_sts;     // [RL1]

  // status writes decode to nothing, so they are dropped
  wire [15:0] irq_status_flags = {overall_sts, 6'h00, src_status,
                                  4'h0};                 // [RL8]

  // ------------------------------------------------------------
  // read data and pin outputs
  // ------------------------------------------------------------
  wire [15:0] next_rdata =
    (reg_index == cmi_pkg::IDX_IRQ_ENABLE) ? irq_enable_control :
    (reg_index == cmi_pkg::IDX_IRQ_STATUS) ? irq_status_flags :
    16'h0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata         <= 16'h0000;
      device_irq        <= 1'b0;
      status_output_pin <= 1'b0;
    end else begin
      reg_rdata         <= next_rdata;
      device_irq        <= irq_gated;                    // [RL1]
      status_output_pin <= status_output_select ? irq_gated
                                                : alt_pin_status; // [RL4]
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_irq_gate;
    @(posedge clk) disable iff (sys_rst)
      !overall_en |=> !device_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [RL1]
    else $error("device irq high with overall enable off");

  property p_irq_follows;
    @(posedge clk) disable iff (sys_rst)
      (overall_en && overall_sts) |=> device_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // [RL1]
    else $error("device irq missing while enabled and pending");

  property p_src_masked;
    @(posedge clk) disable iff (sys_rst)
      (src_enable == 5'h00) |-> !overall_sts;
  endproperty
  a_src_masked: assert property (p_src_masked) // [RL2]
    else $error("overall status set with all sources disabled");

  property p_overall_or;
    @(posedge clk) disable iff (sys_rst)
      (reg_index == cmi_pkg::IDX_IRQ_STATUS)
        |=> reg_rdata[15] == $past(overall_sts);
  endproperty
  a_overall_or: assert property (p_overall_or) // [RL3]
    else $error("overall status read not OR of enabled sources");

  property p_pin_route;
    @(posedge clk) disable iff (sys_rst)
      status_output_select |=> status_output_pin == $past(irq_gated);
  endproperty
  a_pin_route: assert property (p_pin_route) // [RL4]
    else $error("status pin does not carry gated interrupt");

  property p_mirror;
    @(posedge clk) disable iff (sys_rst)
      cond_sync[0] |=> ##1 src_status[0];
  endproperty
  a_mirror: assert property (p_mirror) // [RL5]
    else $error("status bit did not mirror loss event");

  property p_reset_zero;
    @(posedge clk) sys_rst |=> (irq_enable_control == 16'h0000)
                               && (src_status == 5'h00) && !device_irq;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // [RL6]
    else $error("enable or status not zero after reset");

  property p_clear_blocked;
    @(posedge clk) disable iff (sys_rst)
      (cond_sync[2] && clr_bits[2]) |=> evt_flag[2];
  endproperty
  a_clear_blocked: assert property (p_clear_blocked) // [RL7]
    else $error("loss flag cleared while loss persists");

  property p_sts_write_ignored;
    @(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_index == cmi_pkg::IDX_IRQ_STATUS)
        |=> $stable(irq_enable_control);
  endproperty
  a_sts_write_ignored: assert property (p_sts_write_ignored) // [RL8]
    else $error("status write changed the enable register");

  // loss flags come up set so software must acknowledge them once
  property p_flag_reset;
    @(posedge clk) sys_rst |=> (evt_flag == cmi_pkg::FLAG_RESET);
  endproperty
  a_flag_reset: assert property (p_flag_reset) // [RL7]
    else $error("event flags not at their reset value");

  property p_clear_works;
    @(posedge clk) disable iff (sys_rst)
      (clr_bits[0] && !cond_sync[0]) |=> !evt_flag[0];
  endproperty
  a_clear_works: assert property (p_clear_works) // [RL7]
    else $error("loss flag not cleared by a write of one");

  property p_status_copy;
    @(posedge clk) disable iff (sys_rst)
      !sys_rst |=> (src_status == $past(evt_flag));
  endproperty
  a_status_copy: assert property (p_status_copy) // [RL5]
    else $error("status bits do not follow the event flags");

  c_irq_raised: cover property (@(posedge clk) $rose(device_irq));
  c_flag_cleared: cover property (@(posedge clk) $fell(evt_flag[0]));
  c_pin_irq: cover property (@(posedge clk)
    status_output_select && status_output_pin);

endmodule : cmi_irq_aggregator
`default_nettype wire

/* File: verif/cmi_host_model.sv */
// host model that polls the status pin each clock
`timescale 1ns/1ps
`default_nettype none
module cmi_host_model (
  input  wire logic clk,
  input  wire logic pin,
  output var  logic seen
);
  // a poll sees the pin one clock late, as a real port read would
  always_ff @(posedge clk) begin
    seen <= pin;
  end
endmodule : cmi_host_model
`default_nettype wire

/* File: verif/tb_clock_monitor_irq_aggregator.sv */
// self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module tb_clock_monitor_irq_aggregator;
  logic        clk       = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [4:0]  cond      = 5'h00;
  logic [1:0]  reg_index = 2'h0;
  logic        reg_wr    = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        sel       = 1'b0;
  logic        alt       = 1'b0;
  logic [15:0] reg_rdata;
  logic        device_irq;
  logic        status_output_pin;
  logic        seen;
  logic [15:0] v;
  int          fails      = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  always #10 clk = ~clk;
  // cond bit i feeds status bit i+4
  cmi_irq_aggregator dut_u (.clk(clk), .sys_rst(sys_rst),
    .los_pos_cond(cond[0]), .los_neg_cond(cond[1]), .los_xtal_cond(cond[2]),
    .act_pos_cond(cond[3]), .act_neg_cond(cond[4]), .reg_index(reg_index),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .status_output_select(sel), .alt_pin_status(alt),
    .device_irq(device_irq), .status_output_pin(status_output_pin));
  cmi_host_model host_u (.clk(clk), .pin(status_output_pin), .seen(seen));
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk1
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wr(input logic [1:0] i, input logic [15:0] d);
    @(posedge clk);
    reg_index <= i;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [1:0] i);
    @(posedge clk);
    reg_index <= i;
    step(1);
    v = reg_rdata;
  endtask : rdr
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset;
    step(3);
    rdr(2'h0); chk16(v, 16'h0000);
    rdr(2'h1); chk16(v, 16'h0070);
    chk1(device_irq, 1'b0);
    $display("done t_reset");
  endtask : t_reset
  task automatic t_sticky;
    cond <= 5'h04;
    step(6);
    wr(2'h2, 16'h01F0);
    step(2);
    rdr(2'h1); chk16(v, 16'h0040);
    cond <= 5'h18;
    step(1);
    cond <= 5'h00;
    step(6);
    rdr(2'h1); chk16(v, 16'h01C0);
    wr(2'h2, 16'h01F0);
    step(2);
    rdr(2'h1); chk16(v, 16'h0000);
    $display("done t_sticky");
  endtask : t_sticky
  task automatic t_regs;
    wr(2'h0, 16'hFFFF);
    rdr(2'h0); chk16(v, 16'h8FF0);
    wr(2'h1, 16'hFFFF);
    rdr(2'h1); chk16(v, 16'h0000);
    rdr(2'h0); chk16(v, 16'h8FF0);
    rdr(2'h3); chk16(v, 16'h0000);
    wr(2'h0, 16'h0000);
    $display("done t_regs");
  endtask : t_regs
  task automatic t_irq;
    logic [15:0] b;
    for (int i = 0; i < 5; i++) begin
      b = 16'h0010 << i;
      cond <= 5'h01 << i;
      step(6);
      wr(2'h0, 16'h8000 | b);
      sel <= 1'b1;
      step(2);
      chk1(device_irq, 1'b1);
      chk1(seen, 1'b1);
      rdr(2'h1); chk16(v, 16'h8000 | b);
      wr(2'h0, b);
      step(2);
      chk1(device_irq, 1'b0);
      chk1(status_output_pin, 1'b0);
      rdr(2'h1); chk16(v, 16'h8000 | b);
      wr(2'h0, 16'h8000 | (16'h0010 << ((i + 1) % 5)));
      sel <= 1'b0;
      alt <= 1'b1;
      step(2);
      chk1(device_irq, 1'b0);
      chk1(status_output_pin, 1'b1);
      alt  <= 1'b0;
      cond <= 5'h00;
      step(6);
      wr(2'h2, 16'h01F0);
      wr(2'h0, 16'h0000);
    end
    $display("done t_irq");
  endtask : t_irq
  // reset in mid-run must drop a live enable and re-arm the loss flags
  task automatic t_rerun;
    wr(2'h0, 16'h8FF0);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    step(3);
    chk1(device_irq, 1'b0);
    rdr(2'h0); chk16(v, 16'h0000);
    rdr(2'h1); chk16(v, 16'h0070);
    $display("done t_rerun");
  endtask : t_rerun
  // a hang ends the run through the same report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    repeat (7) @(posedge clk);
    #1;
    chk16(reg_rdata, 16'h0000);
    @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_sticky();
    t_regs();
    t_irq();
    t_rerun();
    close_out();
  end
endmodule : tb_clock_monitor_irq_aggregator
`default_nettype wire
